// ### smr_bus_front.sv
// Bus front end: synchronises the microprocessor strobes, makes pulses
// Assumes: strobes asynchronous to CLK, address and data stable around them
`timescale 1ns/1ns
module smr_bus_front (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Pins
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    // Strobes
    smr_bus_if.front        bus
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [1:0] prev;
        logic       wr;
        logic       rd;
        logic [6:0] a;
        logic [7:0] d;
    } smr_front_t;

    smr_front_t st_q;
    smr_front_t st_d;
    logic       acc_rd;
    logic       acc_wr;

    // ----------------------------------------------------------------
    // Strobe decode
    // ----------------------------------------------------------------
    always_comb begin
        st_d       = st_q;
        st_d.s1    = {cs_n, rd_n, wr_n};
        st_d.s2    = st_q.s1;
        acc_rd     = !st_q.s2[2] && !st_q.s2[1];
        acc_wr     = !st_q.s2[2] && !st_q.s2[0];
        st_d.prev  = {acc_rd, acc_wr};
        st_d.rd    = acc_rd && !st_q.prev[1] && !addr[7];
        st_d.wr    = !acc_wr && st_q.prev[0] && !addr[7];
        st_d.a     = addr[6:0];
        st_d.d     = wdata;
        if (!rst_n) begin
            st_d = '0;
            st_d.s1 = 3'h7;
            st_d.s2 = 3'h7;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign bus.rd_stb = st_q.rd;
    assign bus.wr_stb = st_q.wr;
    assign bus.addr   = st_q.a;
    assign bus.wdata  = st_q.d;
endmodule

// ### smr_bus_if.sv
// Interface: decoded register bus strobes between bus front end and bank
// Assumes: single clock domain
`timescale 1ns/1ns
interface smr_bus_if;
    logic       wr_stb;
    logic       rd_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    modport front (output wr_stb, output rd_stb, output addr, output wdata);
    modport bank  (input wr_stb, input rd_stb, input addr, input wdata);
endinterface

// ### smr_cpu_model.sv
// Microprocessor model: drives the 8-bit register bus of the master bank
// Assumes: strobes changed on the falling clock edge, answers on DATA_OE
`timescale 1ns/1ns
module smr_cpu_model (
    // Clock
    input  wire logic       clk,
    // Bus pins toward the device
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    // Read answer from the device
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    initial begin
        cs_n  = 1'h1;
        rd_n  = 1'h1;
        wr_n  = 1'h1;
        addr  = 8'h00;
        wdata = 8'h00;
    end

    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    // select held
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cs_n  = 1'h0;
        addr  = a;
        wdata = d;
        repeat (2) @(negedge clk);
        wr_n = 1'h0;
        repeat (3) @(negedge clk);
        wr_n = 1'h1;
        repeat (5) @(negedge clk);
        cs_n  = 1'h1;
        wdata = ~d;
        addr  = ~a;
        repeat (2) @(negedge clk);
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        d = 8'hxx;
        @(negedge clk);
        cs_n = 1'h0;
        addr = a;
        repeat (2) @(negedge clk);
        rd_n = 1'h0;
        while (n < 12) begin
            @(posedge clk);
            #1;
            n++;
            if (data_oe === 1'h1) begin
                d = data_out;
                n = 12;
            end
        end
        @(negedge clk);
        rd_n = 1'h1;
        repeat (5) @(negedge clk);
        cs_n = 1'h1;
        addr = ~a;
        repeat (2) @(negedge clk);
    endtask
endmodule

// ### smr_master_regs.sv
// Master register bank: reset, identity, meter load, configuration,
// interrupt summary and line rate.
// Assumes: block interrupt and alarm inputs come from logic on CLK;
// bus pins are asynchronous and pass the front end.
`timescale 1ns/1ns

module smr_master_regs #(
    parameter int XFER_CYCLES = smr_pkg::XFER_CYC
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RESETN,
    // Microprocessor bus
    input  wire logic       CHIP_SELECT_N,
    input  wire logic       RD_N,
    input  wire logic       WR_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] DATA_IN,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE,
    output logic            IRQ_OUT_N,
    // Block interrupt requests and cell delineation state
    input  wire logic       RX_SECTION_PROC_IRQ,
    input  wire logic       RX_LINE_PROC_IRQ,
    input  wire logic       RX_PATH_PROC_IRQ,
    input  wire logic       RX_CELL_PROC_IRQ,
    input  wire logic       TX_CELL_PROC_IRQ,
    input  wire logic       CLK_RECOVERY_IRQ,
    input  wire logic       CLK_SYNTH_IRQ,
    input  wire logic       CELL_DELIN_LOSS,
    // Alarms and error events
    input  wire logic       LOS,
    input  wire logic       LOF,
    input  wire logic       LINE_AIS,
    input  wire logic       LOP,
    input  wire logic       PATH_AIS,
    input  wire logic       LINE_BIP_ERR,
    input  wire logic       PATH_BIP_ERR,
    // Cell availability from the FIFOs
    input  wire logic       RX_CELL_READY,
    input  wire logic       TX_CELL_ROOM,
    // Transfer done from counter blocks
    input  wire logic       METER_DONE,
    // Device control outputs
    output logic            DEVICE_RESET,
    output logic            STANDBY,
    output logic            METER_LOAD,
    output logic            TX_FRAME_PULSE_IS_INPUT,
    output logic            RX_CELL_AVAIL,
    output logic            TX_CELL_AVAIL,
    output logic            PATH_RDI_INSERT,
    output logic            LINE_RDI_INSERT,
    output logic            LINE_FEBE,
    output logic            PATH_FEBE,
    output logic      [1:0] LINE_RATE
);
    typedef struct packed {
        logic       srst;
        logic       busy;
        logic [7:0] xcnt;
        logic       load;
        logic [7:0] cfg;
        logic [1:0] rate;
        logic       delin_prev;
        logic       delin_irq;
        logic [7:0] rdata;
        logic       oe;
        logic       irq_n;
        logic       rx_avail;
        logic       tx_avail;
        logic       prdi;
        logic       lrdi;
        logic       lfebe;
        logic       pfebe;
    } smr_state_t;

    smr_state_t st_q;
    smr_state_t st_d;
    logic [7:0] summary;
    logic       dev_rst;
    logic       wr_reg0;

    smr_bus_if bus ();

    smr_bus_front u_front (
        .clk   (CLK),
        .rst_n (RESETN),
        .cs_n  (CHIP_SELECT_N),
        .rd_n  (RD_N),
        .wr_n  (WR_N),
        .addr  (ADDR),
        .wdata (DATA_IN),
        .bus   (bus.front)
    );

    function automatic logic is_wr(input logic stb, input logic [6:0] a,
                                   input logic [6:0] off);
        is_wr = stb && (a == off);
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        summary = {CLK_SYNTH_IRQ, st_q.delin_irq, CLK_RECOVERY_IRQ, TX_CELL_PROC_IRQ,
                   RX_CELL_PROC_IRQ, RX_PATH_PROC_IRQ, RX_LINE_PROC_IRQ,
                   RX_SECTION_PROC_IRQ};
        dev_rst = st_q.srst;
        wr_reg0 = is_wr(bus.wr_stb, bus.addr, smr_pkg::OFF_RESET_ID);

        if (wr_reg0) begin
            st_d.srst = bus.wdata[smr_pkg::SRST_BIT];
        end

        // soft reset restores transfer, configuration, rate and delineation state to their reset values
        if (dev_rst) begin
            st_d.busy       = 1'b0;
            st_d.xcnt       = '0;
            st_d.load       = 1'b0;
            st_d.cfg        = smr_pkg::CFG_RESET;
            st_d.rate       = smr_pkg::RATE_RESET;
            st_d.delin_irq  = 1'b0;
            st_d.delin_prev = CELL_DELIN_LOSS;
        end else begin
            st_d.load = 1'b0;
            if (wr_reg0 && !bus.wdata[smr_pkg::SRST_BIT]) begin
                st_d.busy = 1'b1;
                st_d.load = 1'b1;
                st_d.xcnt = 8'(XFER_CYCLES);
            end else if (st_q.busy) begin
                if (st_q.xcnt != 8'h00) begin
                    st_d.xcnt = st_q.xcnt - 8'h01;
                end else if (METER_DONE) begin
                    st_d.busy = 1'b0;
                end
            end
            if (is_wr(bus.wr_stb, bus.addr, smr_pkg::OFF_CONFIG)) begin
                st_d.cfg = bus.wdata & smr_pkg::CFG_WMASK;
            end
            if (is_wr(bus.wr_stb, bus.addr, smr_pkg::OFF_RATE_SEL)) begin
                st_d.rate = bus.wdata[1:0];
            end
            // delineation change, set wins over read clear
            st_d.delin_prev = CELL_DELIN_LOSS;
            if (CELL_DELIN_LOSS != st_q.delin_prev) begin
                st_d.delin_irq = 1'b1;
            end else if (bus.rd_stb && bus.addr == smr_pkg::OFF_IRQ_SUM) begin
                st_d.delin_irq = 1'b0;
            end
        end

        // Read data
        st_d.oe = bus.rd_stb;
        if (bus.rd_stb) begin
            case (bus.addr)
                smr_pkg::OFF_RESET_ID: begin
                    st_d.rdata = {st_q.srst, smr_pkg::TYPE_CODE, st_q.busy,
                                  smr_pkg::REV_CODE};
                end
                smr_pkg::OFF_CONFIG:   st_d.rdata = st_q.cfg;
                smr_pkg::OFF_IRQ_SUM:  st_d.rdata = summary;
                smr_pkg::OFF_RATE_SEL: st_d.rdata = {6'h00, st_q.rate};
                default:               st_d.rdata = 8'h00;
            endcase
        end

        st_d.irq_n = ~(|summary);
        st_d.rx_avail = RX_CELL_READY ^ st_q.cfg[smr_pkg::CFG_RX_CELL_AVAIL_INVERT];
        st_d.tx_avail = TX_CELL_ROOM ^ st_q.cfg[smr_pkg::CFG_TX_CELL_AVAIL_INVERT];
        st_d.prdi  = !dev_rst && st_q.cfg[smr_pkg::CFG_AUTO_PRDI] &&
                     (LOS || LOF || LINE_AIS || LOP || PATH_AIS);
        st_d.lrdi  = !dev_rst && st_q.cfg[smr_pkg::CFG_AUTO_LRDI] &&
                     (LOS || LOF || LINE_AIS);
        st_d.lfebe = !dev_rst && st_q.cfg[smr_pkg::CFG_AUTO_FEBE] && LINE_BIP_ERR;
        st_d.pfebe = !dev_rst && st_q.cfg[smr_pkg::CFG_AUTO_FEBE] && PATH_BIP_ERR;

        if (!RESETN) begin
            st_d       = '0;
            st_d.cfg   = smr_pkg::CFG_RESET;
            st_d.rate  = smr_pkg::RATE_RESET;
            st_d.irq_n = 1'b1;
            // Track the pin so no false change follows reset
            st_d.delin_prev = CELL_DELIN_LOSS;
        end
    end

    always_ff @(posedge CLK) begin
        st_q <= st_d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign DATA_OUT        = st_q.rdata;
    assign DATA_OE         = st_q.oe;
    assign IRQ_OUT_N       = st_q.irq_n;
    assign DEVICE_RESET    = st_q.srst;
    assign STANDBY         = st_q.srst;
    assign METER_LOAD      = st_q.load;
    assign TX_FRAME_PULSE_IS_INPUT = st_q.cfg[smr_pkg::CFG_TX_FRAME_PULSE_IN];
    assign RX_CELL_AVAIL   = st_q.rx_avail;
    assign TX_CELL_AVAIL   = st_q.tx_avail;
    assign PATH_RDI_INSERT = st_q.prdi;
    assign LINE_RDI_INSERT = st_q.lrdi;
    assign LINE_FEBE       = st_q.lfebe;
    assign PATH_FEBE       = st_q.pfebe;
    assign LINE_RATE       = st_q.rate;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_start;
        is_wr(bus.wr_stb, bus.addr, smr_pkg::OFF_RESET_ID) &&
        !bus.wdata[smr_pkg::SRST_BIT] && !st_q.srst;
    endsequence

    sequence s_sum_read;
        bus.rd_stb && bus.addr == smr_pkg::OFF_IRQ_SUM;
    endsequence

    AST_XFER_SET: assert property (@(posedge CLK) disable iff (!RESETN)
        s_start |=> st_q.busy && METER_LOAD)
        else $error("transfer flag not set by meter write");
    AST_XFER_READ: assert property (@(posedge CLK) disable iff (!RESETN)
        bus.rd_stb && bus.addr == smr_pkg::OFF_RESET_ID |=>
        DATA_OE && DATA_OUT[smr_pkg::TRANSFER_IN_PROGRESS_BIT] == $past(st_q.busy))
        else $error("transfer flag not shown on read");
    AST_LOAD_PULSE: assert property (@(posedge CLK) disable iff (!RESETN)
        METER_LOAD |=> !METER_LOAD || $past(wr_reg0))
        else $error("meter load longer than one cycle");
    AST_SRST_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
        st_q.srst && !wr_reg0 |=> st_q.srst)
        else $error("software reset cleared itself");
    AST_STANDBY: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_reg0 && bus.wdata[smr_pkg::SRST_BIT] |=> STANDBY && DEVICE_RESET)
        else $error("standby not entered on software reset");
    AST_SRST_CFG: assert property (@(posedge CLK) disable iff (!RESETN)
        st_q.srst |=> st_q.cfg == smr_pkg::CFG_RESET)
        else $error("soft reset did not restore configuration");
    AST_DELIN_SET: assert property (@(posedge CLK) disable iff (!RESETN)
        !st_q.srst && $changed(CELL_DELIN_LOSS) |=> st_q.delin_irq)
        else $error("delineation change not flagged");
    AST_DELIN_CLEAR: assert property (@(posedge CLK) disable iff (!RESETN)
        s_sum_read ##0 (CELL_DELIN_LOSS == st_q.delin_prev)
        |=> !summary[smr_pkg::CELL_DELIN_LOSS_IRQ_BIT])
        else $error("delineation flag not cleared by read");
    AST_IRQ: assert property (@(posedge CLK) disable iff (!RESETN)
        (|summary) |=> !IRQ_OUT_N)
        else $error("interrupt output not asserted");
    AST_IRQ_IDLE: assert property (@(posedge CLK) disable iff (!RESETN)
        !(|summary) |=> IRQ_OUT_N)
        else $error("interrupt output not released");
    AST_LINE_RDI: assert property (@(posedge CLK) disable iff (!RESETN)
        !st_q.srst && st_q.cfg[smr_pkg::CFG_AUTO_LRDI] && (LOS || LOF || LINE_AIS)
        |=> LINE_RDI_INSERT)
        else $error("line remote defect not inserted");
    AST_PATH_RDI: assert property (@(posedge CLK) disable iff (!RESETN)
        !st_q.srst && st_q.cfg[smr_pkg::CFG_AUTO_PRDI] &&
        (LOS || LOF || LINE_AIS || LOP || PATH_AIS) |=> PATH_RDI_INSERT)
        else $error("path remote defect not inserted");
    AST_RATE_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
        is_wr(bus.wr_stb, bus.addr, smr_pkg::OFF_RATE_SEL) && !st_q.srst
        |=> LINE_RATE == $past(bus.wdata[1:0]))
        else $error("line rate not taken from write");
    AST_FRAME_DIR: assert property (@(posedge CLK) disable iff (!RESETN)
        is_wr(bus.wr_stb, bus.addr, smr_pkg::OFF_CONFIG) && !st_q.srst
        |=> TX_FRAME_PULSE_IS_INPUT == $past(bus.wdata[smr_pkg::CFG_TX_FRAME_PULSE_IN]))
        else $error("frame pulse direction not taken from write");
    AST_FEBE_OFF: assert property (@(posedge CLK) disable iff (!RESETN)
        !st_q.cfg[smr_pkg::CFG_AUTO_FEBE] |=> !LINE_FEBE && !PATH_FEBE)
        else $error("far end error sent while disabled");
    AST_RX_AVAIL: assert property (@(posedge CLK) disable iff (!RESETN)
        RESETN |=> RX_CELL_AVAIL ==
            ($past(RX_CELL_READY) ^ $past(st_q.cfg[smr_pkg::CFG_RX_CELL_AVAIL_INVERT])))
        else $error("receive cell available polarity wrong");
    AST_TX_AVAIL: assert property (@(posedge CLK) disable iff (!RESETN)
        RESETN |=> TX_CELL_AVAIL ==
            ($past(TX_CELL_ROOM) ^ $past(st_q.cfg[smr_pkg::CFG_TX_CELL_AVAIL_INVERT])))
        else $error("transmit cell available polarity wrong");
endmodule

// ### smr_master_regs_bench.sv
// Testbench of the master register bank, random and corner stimulus
// Assumes: design compiled with smr_pkg and smr_cpu_model
`timescale 1ns/1ns
module smr_master_regs_bench;
    localparam int XFER = 4;
    logic       clk, resetn, cs_n, rd_n, wr_n, data_oe, irq_n, delin, meter_done;
    logic [7:0] addr, wdata, data_out, irq_vec, v, id_exp;
    logic [4:0] alarm;
    logic       line_bip, path_bip, rx_ready, tx_room, dev_rst, standby, meter_load;
    logic       frame_in, rx_avail, tx_avail, prdi, lrdi, lfebe, pfebe;
    logic [1:0] rate;
    int         err_total, total_checks, seed, loads, lfebe_cnt, pfebe_cnt;

    smr_cpu_model smr_cpu_model_inst (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .wdata(wdata), .data_out(data_out), .data_oe(data_oe));

    smr_master_regs #(.XFER_CYCLES(XFER)) smr_master_regs_inst (
        .CLK(clk), .RESETN(resetn), .CHIP_SELECT_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
        .ADDR(addr), .DATA_IN(wdata), .DATA_OUT(data_out), .DATA_OE(data_oe),
        .IRQ_OUT_N(irq_n), .RX_SECTION_PROC_IRQ(irq_vec[0]), .RX_LINE_PROC_IRQ(irq_vec[1]),
        .RX_PATH_PROC_IRQ(irq_vec[2]), .RX_CELL_PROC_IRQ(irq_vec[3]),
        .TX_CELL_PROC_IRQ(irq_vec[4]), .CLK_RECOVERY_IRQ(irq_vec[5]),
        .CLK_SYNTH_IRQ(irq_vec[7]), .CELL_DELIN_LOSS(delin), .LOS(alarm[4]), .LOF(alarm[3]),
        .LINE_AIS(alarm[2]), .LOP(alarm[1]), .PATH_AIS(alarm[0]), .LINE_BIP_ERR(line_bip),
        .PATH_BIP_ERR(path_bip), .RX_CELL_READY(rx_ready), .TX_CELL_ROOM(tx_room),
        .METER_DONE(meter_done), .DEVICE_RESET(dev_rst), .STANDBY(standby),
        .METER_LOAD(meter_load), .TX_FRAME_PULSE_IS_INPUT(frame_in), .RX_CELL_AVAIL(rx_avail),
        .TX_CELL_AVAIL(tx_avail), .PATH_RDI_INSERT(prdi), .LINE_RDI_INSERT(lrdi),
        .LINE_FEBE(lfebe), .PATH_FEBE(pfebe), .LINE_RATE(rate));

    // ----------------------------------------------------------------
    // Clock, pulse counters, watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // Pulses counted mid-cycle, where they are settled
    always @(negedge clk) begin
        if (meter_load === 1'h1) loads++;
        if (lfebe === 1'h1) lfebe_cnt++;
        if (pfebe === 1'h1) pfebe_cnt++;
    end

    initial begin
        #100000;
        err_total++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // Compare and access tasks
    // ----------------------------------------------------------------
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check1(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        smr_cpu_model_inst.read_reg(a, d);
        check8(name, exp, d);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        smr_cpu_model_inst.write_reg(a, d);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 53470;
        {resetn, irq_vec, delin, alarm, line_bip, path_bip, rx_ready, tx_room} = '0;
        meter_done = 1'h1;
        id_exp = {1'h0, smr_pkg::TYPE_CODE, 1'h0, smr_pkg::REV_CODE};
        repeat (3) @(negedge clk);
        resetn = 1'h1;
        repeat (4) @(negedge clk);
        rd(8'h00, id_exp, "identity");
        rd(8'h01, smr_pkg::CFG_RESET, "config_default");
        check1("frame_pulse_dir", 1'h1, frame_in);
        for (int r = 2; r < 5; r++) begin
            wr(8'h03, 8'(r % 2 + 2));
            rd(8'h03, 8'(r % 2 + 2), "rate_readback");
            check8("line_rate", 8'(r % 2 + 2), {6'h00, rate});
        end
        for (int i = 0; i < 14; i++) begin
            v = 8'($random(seed));
            v[1] = 1'h0;
            if (i == 0) v = 8'h80;
            if (i == 1) v = 8'h7d;
            {alarm, rx_ready, tx_room} = 7'($random(seed));
            if (i < 2) alarm = 5'h04;
            wr(8'h01, v);
            rd(8'h01, v & 8'h7f, "config_readback");
            check1("frame_pulse_dir", v[0], frame_in);
            check1("rx_cell_avail", rx_ready ^ v[2], rx_avail);
            check1("tx_cell_avail", tx_room ^ v[3], tx_avail);
            check1("path_rdi", v[4] & (|alarm), prdi);
            check1("line_rdi", v[5] & (|alarm[4:2]), lrdi);
            lfebe_cnt = 0;
            pfebe_cnt = 0;
            line_bip = 1'h1;
            @(negedge clk);
            line_bip = 1'h0;
            path_bip = 1'h1;
            @(negedge clk);
            path_bip = 1'h0;
            repeat (4) @(negedge clk);
            check8("line_febe_count", {7'h00, v[6]}, 8'(lfebe_cnt));
            check8("path_febe_count", {7'h00, v[6]}, 8'(pfebe_cnt));
        end
        alarm = 5'h00;
        wr(8'h01, 8'h71);
        wr(8'h81, 8'h00);
        rd(8'h01, 8'h71, "test_set_write");
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h00, "summary_write");
        for (int i = 0; i < 6; i++) begin
            irq_vec = (i == 0) ? 8'hbf : 8'($random(seed)) & 8'hbf;
            repeat (2) @(negedge clk);
            check1("irq_out_n", ~(|irq_vec), irq_n);
            rd(8'h02, irq_vec, "summary");
            rd(8'h02, irq_vec, "summary_again");
        end
        irq_vec = 8'h00;
        for (int i = 0; i < 2; i++) begin
            delin = ~delin;
            repeat (3) @(negedge clk);
            check1("irq_out_n_delin", 1'h0, irq_n);
            rd(8'h02, 8'h40, "delin_change");
            rd(8'h02, 8'h00, "delin_cleared");
            check1("irq_out_n_idle", 1'h1, irq_n);
        end
        meter_done = 1'h0;
        loads = 0;
        wr(8'h00, 8'h7f);
        check8("meter_loads", 8'h01, 8'(loads));
        rd(8'h00, id_exp | 8'h08, "transfer_busy");
        meter_done = 1'h1;
        repeat (XFER + 4) @(negedge clk);
        rd(8'h00, id_exp, "transfer_done");
        wr(8'h01, 8'h00);
        wr(8'h03, 8'h02);
        loads = 0;
        wr(8'h00, 8'h80);
        check1("device_reset", 1'h1, dev_rst);
        check1("standby", 1'h1, standby);
        check8("reset_loads", 8'h00, 8'(loads));
        repeat (20) @(negedge clk);
        check1("reset_held", 1'h1, dev_rst);
        wr(8'h00, 8'h00);
        check1("reset_released", 1'h0, dev_rst);
        rd(8'h01, smr_pkg::CFG_RESET, "config_after_soft");
        rd(8'h03, 8'h03, "rate_after_soft");
        wr(8'h00, 8'h80);
        resetn = 1'h0;
        repeat (3) @(negedge clk);
        resetn = 1'h1;
        repeat (4) @(negedge clk);
        check1("hard_clears_soft", 1'h0, dev_rst);
        check1("standby_after_hard", 1'h0, standby);
        complete_run();
    end
endmodule

// ### smr_pkg.sv
// Package: constants of the master register bank
// Assumes: 8-bit microprocessor bus, normal set at address bit 7 low
package smr_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [6:0] OFF_RESET_ID  = 7'h00;
    localparam logic [6:0] OFF_CONFIG    = 7'h01;
    localparam logic [6:0] OFF_IRQ_SUM   = 7'h02;
    localparam logic [6:0] OFF_RATE_SEL  = 7'h03;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SRST_BIT        = 7;
    localparam int TRANSFER_IN_PROGRESS_BIT = 3;
    localparam int TYPE_LSB        = 4;
    localparam int CFG_TX_FRAME_PULSE_IN    = 0;
    localparam int CFG_RSVD        = 1;
    localparam int CFG_RX_CELL_AVAIL_INVERT = 2;
    localparam int CFG_TX_CELL_AVAIL_INVERT = 3;
    localparam int CFG_AUTO_PRDI   = 4;
    localparam int CFG_AUTO_LRDI   = 5;
    localparam int CFG_AUTO_FEBE   = 6;
    localparam int CELL_DELIN_LOSS_IRQ_BIT  = 6;
    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] CFG_RESET    = 8'h71;
    localparam logic [7:0] CFG_WMASK    = 8'h7f;
    localparam logic [1:0] RATE_RESET   = 2'h3;
    localparam logic [1:0] RATE_STS1    = 2'h2;
    localparam logic [1:0] RATE_STS3C   = 2'h3;
    // Arbitrary identity values
    localparam logic [2:0] TYPE_CODE    = 3'h5;
    localparam logic [2:0] REV_CODE     = 3'h2;
    // Performance meter transfer length in ns
    localparam int XFER_NS     = 32;
    localparam int CLK_NS      = 4;
    localparam int XFER_CYC    = (XFER_NS + CLK_NS - 1) / CLK_NS;
endpackage
